//--- logic/adhp_pkg.sv
package adhp_pkg;
    localparam int unsigned BUS_W = 16;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned QUAD_W = 32;
    localparam int unsigned LEN_W = 3;
    localparam int unsigned STEP_W = 2;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFS_FIFO_CLR = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h94;

    localparam int unsigned TX_CLR_BIT = 31;
    localparam int unsigned RX_CLR_BIT = 30;
    localparam int unsigned TRIS_BIT = 31;
    localparam int unsigned IN_RST_BIT = 30;
    localparam int unsigned OUT_RST_BIT = 29;
    localparam int unsigned LE_BIT = 16;
    localparam int unsigned WIDE_BIT = 0;
    localparam int unsigned SYNC_BIT = 1;
    localparam int unsigned LEN_LO = 8;
    localparam int unsigned LEN_FLD_W = 2;

    localparam int unsigned ST_RX_FULL = 0;
    localparam int unsigned ST_TX_FULL = 1;
    localparam int unsigned ST_BUSY = 2;
    localparam int unsigned ST_AVAIL = 3;

    localparam logic [LEN_W-1:0] LEN_FULL = 3'h4;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

    localparam int unsigned CLK_NS = 4;
    localparam int unsigned STROBE_NS = 25;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC - 1);

    typedef logic [BUS_W-1:0] adhp_word_t;
    typedef logic [QUAD_W-1:0] adhp_quad_t;
    typedef logic [LEN_W-1:0] adhp_len_t;
endpackage : adhp_pkg

//--- logic/adhp_if.sv
`timescale 1ns/1ps
interface adhp_if;
    import adhp_pkg::*;
    logic input_strobe;
    logic output_strobe;
    logic input_busy_flag;
    logic output_available_flag;
    adhp_word_t dev_dout;
    logic dev_oe_hi_n;
    logic dev_oe_lo_n;
    adhp_word_t host_dout;
    logic host_oe_n;
    adhp_word_t port_data_bus;

    // Wire level; an undriven lane reads as zero
    assign port_data_bus[15:8] = !dev_oe_hi_n ? dev_dout[15:8] :
        (!host_oe_n ? host_dout[15:8] : 8'h00);
    assign port_data_bus[7:0] = !dev_oe_lo_n ? dev_dout[7:0] :
        (!host_oe_n ? host_dout[7:0] : 8'h00);

    modport dev (
        input input_strobe,
        input output_strobe,
        output input_busy_flag,
        output output_available_flag,
        output dev_dout,
        output dev_oe_hi_n,
        output dev_oe_lo_n,
        input port_data_bus
    );
    modport host (
        output input_strobe,
        output output_strobe,
        input input_busy_flag,
        input output_available_flag,
        output host_dout,
        output host_oe_n,
        input port_data_bus
    );
endinterface : adhp_if

//--- logic/adhp_order.sv
`timescale 1ns/1ps
module adhp_order
    import adhp_pkg::*;
(
    input wire logic wide,
    input wire logic le,
    input wire adhp_pkg::adhp_len_t len,
    input wire logic [adhp_pkg::STEP_W-1:0] step,
    output logic [adhp_pkg::STEP_W-1:0] hi_idx,
    output logic [adhp_pkg::STEP_W-1:0] lo_idx,
    output logic hi_ok,
    output logic lo_ok,
    output logic last
);
    import adhp_pkg::*;
    logic [STEP_W-1:0] base;
    logic [STEP_W-1:0] len_m1;

    always_comb
    begin
        base = {step[0] ^ le, 1'b0};
        len_m1 = STEP_W'(len - 3'h1);
        if (wide)
        begin
            hi_idx = base;
            lo_idx = base | 2'h1;
            hi_ok = {1'b0, hi_idx} < len;
            lo_ok = {1'b0, lo_idx} < len;
            last = step[0];
        end
        else
        begin
            hi_idx = 2'h0;
            hi_ok = 1'b0;
            // Only valid bytes are stepped, so padding never goes out
            lo_idx = le ? STEP_W'(len_m1 - step) : step;
            lo_ok = 1'b1;
            last = step == len_m1;
        end
    end
endmodule : adhp_order

//--- logic/adhp_dev.sv
// Functional notes
// - Write data valid at input strobe fall
// - Strobe only while busy flag is low
// - Wide writes never cross quadlet boundary
// - One strobe low-high cycle per word
// - Output strobe only after available flag
// - Endian select bit picks byte order
// - Narrow mode drops padding bytes; wide mode sends them as zero
// - Narrow big endian: D0 D1 D2 D3
// - Narrow little endian: reversed valid bytes
// - Wide big endian: {D0,D1} then {D2,D3}; in wide sync mode reads send {00,D1} then {00,D3}
// - Wide little endian: {D2,D3} then {D0,D1}; in wide sync mode reads send {00,D3} then {00,D1}
// - Both clear bits flush data, 2-3 cycles
// - Both reset bits reset port, 2-3 cycles
// - Tristate bit releases upper data lanes
// - Narrow sync mode keeps upper lanes driven
`timescale 1ns/1ps
module adhp_dev
    import adhp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    adhp_if.dev port,
    input wire logic [adhp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [adhp_pkg::DATA_W-1:0] avs_writedata,
    output logic [adhp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output adhp_pkg::adhp_quad_t rx_quadlet,
    output adhp_pkg::adhp_len_t rx_len,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire adhp_pkg::adhp_quad_t tx_quadlet,
    input wire adhp_pkg::adhp_len_t tx_len,
    input wire logic tx_valid,
    output logic tx_ready
);
    import adhp_pkg::*;

    logic wait_r;
    logic [DATA_W-1:0] rdata_r;
    logic tris_r;
    logic le_r;
    logic wide_r;
    logic sync_r;
    logic [LEN_FLD_W-1:0] len_fld_r;
    logic flush_p1_r;
    logic flush_r;
    logic istb_q_r;
    logic ostb_q_r;
    logic [STEP_W-1:0] wstep_r;
    adhp_quad_t wq_r;
    logic rx_valid_r;
    adhp_len_t wlen;
    logic busy_r;
    logic [STEP_W-1:0] rstep_r;
    adhp_quad_t tq_r;
    adhp_len_t tlen_r;
    logic t_full_r;
    logic tx_ready_r;
    logic avail_r;
    adhp_word_t dout_r;
    logic oe_lo_n_r;
    logic oe_hi_n_r;
    logic req;
    logic wr_hit;
    logic istb_fall;
    logic ostb_rise;
    logic ostb_fall;
    logic [STEP_W-1:0] w_hi_idx;
    logic [STEP_W-1:0] w_lo_idx;
    logic w_hi_ok;
    logic w_lo_ok;
    logic w_last;
    logic [STEP_W-1:0] r_hi_idx;
    logic [STEP_W-1:0] r_lo_idx;
    logic r_hi_ok;
    logic r_lo_ok;
    logic r_last;
    logic [LANE_W-1:0] r_hi_byte;
    logic [LANE_W-1:0] r_lo_byte;
    adhp_quad_t wq_nxt;

    assign req = avs_read | avs_write;
    assign wr_hit = avs_write & !wait_r;
    assign istb_fall = istb_q_r & !port.input_strobe;
    assign ostb_rise = !ostb_q_r & port.output_strobe;
    assign ostb_fall = ostb_q_r & !port.output_strobe;
    // Zero in the length field means a full quadlet
    assign wlen = (len_fld_r == 2'h0) ? LEN_FULL : {1'b0, len_fld_r};

    // One wait state on every access, then the answer
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            wait_r <= 1'b1;
        else if (!wait_r)
            wait_r <= 1'b1;
        else if (req)
            wait_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= REG_RESET;
        else if (req && wait_r)
        begin
            rdata_r <= REG_RESET;
            if (avs_read && avs_address == OFS_FIFO_CLR)
            begin
                rdata_r[ST_RX_FULL] <= rx_valid_r;
                rdata_r[ST_TX_FULL] <= t_full_r;
                rdata_r[ST_BUSY] <= busy_r;
                rdata_r[ST_AVAIL] <= avail_r;
            end
            else if (avs_read && avs_address == OFS_MODE)
            begin
                rdata_r[TRIS_BIT] <= tris_r;
                rdata_r[LE_BIT] <= le_r;
                rdata_r[WIDE_BIT] <= wide_r;
                rdata_r[SYNC_BIT] <= sync_r;
                rdata_r[LEN_LO +: LEN_FLD_W] <= len_fld_r;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tris_r <= 1'b0;
            le_r <= 1'b0;
            wide_r <= 1'b0;
            sync_r <= 1'b0;
            len_fld_r <= 2'h0;
        end
        else if (wr_hit && avs_address == OFS_MODE)
        begin
            tris_r <= avs_writedata[TRIS_BIT];
            le_r <= avs_writedata[LE_BIT];
            wide_r <= avs_writedata[WIDE_BIT];
            sync_r <= avs_writedata[SYNC_BIT];
            len_fld_r <= avs_writedata[LEN_LO +: LEN_FLD_W];
        end
    end

    // Two-stage pipe puts the clear at the second edge after the write
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flush_p1_r <= 1'b0;
            flush_r <= 1'b0;
        end
        else
        begin
            flush_p1_r <= wr_hit && ((avs_address == OFS_FIFO_CLR &&
                avs_writedata[TX_CLR_BIT] && avs_writedata[RX_CLR_BIT]) ||
                (avs_address == OFS_MODE && avs_writedata[OUT_RST_BIT] &&
                avs_writedata[IN_RST_BIT]));
            flush_r <= flush_p1_r;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            istb_q_r <= 1'b0;
            ostb_q_r <= 1'b0;
        end
        else
        begin
            istb_q_r <= port.input_strobe;
            ostb_q_r <= port.output_strobe;
        end
    end

    adhp_order u_word_order (
        .wide(wide_r),
        .le(le_r),
        .len(wlen),
        .step(wstep_r),
        .hi_idx(w_hi_idx),
        .lo_idx(w_lo_idx),
        .hi_ok(w_hi_ok),
        .lo_ok(w_lo_ok),
        .last(w_last)
    );

    adhp_order u_read_order (
        .wide(wide_r),
        .le(le_r),
        .len(tlen_r),
        .step(rstep_r),
        .hi_idx(r_hi_idx),
        .lo_idx(r_lo_idx),
        .hi_ok(r_hi_ok),
        .lo_ok(r_lo_ok),
        .last(r_last)
    );

    // Byte k of a quadlet is Dk, D0 in the top lane
    for (genvar k = 0; k < 4; k++)
    begin : g_byte
        always_comb
        begin
            wq_nxt[QUAD_W-1-LANE_W*k -: LANE_W] = (wstep_r == 2'h0) ?
                8'h00 : wq_r[QUAD_W-1-LANE_W*k -: LANE_W];
            if (w_hi_ok && w_hi_idx == k)
                wq_nxt[QUAD_W-1-LANE_W*k -: LANE_W] =
                    port.port_data_bus[15:8];
            if (w_lo_ok && w_lo_idx == k)
                wq_nxt[QUAD_W-1-LANE_W*k -: LANE_W] =
                    port.port_data_bus[7:0];
        end
    end

    assign r_hi_byte = r_hi_ok ? tq_r[QUAD_W-1-LANE_W*r_hi_idx -: LANE_W] :
        8'h00;
    assign r_lo_byte = r_lo_ok ? tq_r[QUAD_W-1-LANE_W*r_lo_idx -: LANE_W] :
        8'h00;

    // Inbound path: one holding quadlet toward the serial side
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wstep_r <= 2'h0;
            wq_r <= 32'h0000_0000;
            rx_valid_r <= 1'b0;
        end
        else if (flush_r)
        begin
            wstep_r <= 2'h0;
            wq_r <= 32'h0000_0000;
            rx_valid_r <= 1'b0;
        end
        else
        begin
            if (rx_valid_r && rx_ready)
                rx_valid_r <= 1'b0;
            if (istb_fall && !rx_valid_r)
            begin
                wq_r <= wq_nxt;
                wstep_r <= w_last ? 2'h0 : STEP_W'(wstep_r + 2'h1);
                if (w_last)
                    rx_valid_r <= 1'b1;
            end
        end
    end

    // Busy while the input strobe is high or nothing more can be taken
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            busy_r <= 1'b1;
        else
            busy_r <= port.input_strobe | flush_r | flush_p1_r |
                (rx_valid_r & !rx_ready) | (istb_fall & w_last);
    end

    // Outbound path: one quadlet from the serial side, word by word
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstep_r <= 2'h0;
            tq_r <= 32'h0000_0000;
            tlen_r <= LEN_FULL;
            t_full_r <= 1'b0;
            tx_ready_r <= 1'b0;
            avail_r <= 1'b0;
        end
        else if (flush_r)
        begin
            rstep_r <= 2'h0;
            t_full_r <= 1'b0;
            tx_ready_r <= 1'b0;
            avail_r <= 1'b0;
        end
        else if (!t_full_r)
        begin
            tx_ready_r <= !(tx_valid && tx_ready_r);
            if (tx_valid && tx_ready_r)
            begin
                tq_r <= tx_quadlet;
                tlen_r <= tx_len;
                t_full_r <= 1'b1;
                avail_r <= 1'b1;
            end
        end
        else if (ostb_rise)
            avail_r <= 1'b0;
        else if (ostb_fall)
        begin
            rstep_r <= r_last ? 2'h0 : STEP_W'(rstep_r + 2'h1);
            t_full_r <= !r_last;
            tx_ready_r <= r_last;
            avail_r <= !r_last;
        end
    end

    // Low lanes driven only while the reader holds its strobe high; narrow sync mode drives the upper lanes always
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dout_r <= 16'h0000;
            oe_lo_n_r <= 1'b1;
            oe_hi_n_r <= 1'b1;
        end
        else
        begin
            dout_r <= (wide_r && !sync_r) ? {r_hi_byte, r_lo_byte} :
                {8'h00, r_lo_byte};
            oe_lo_n_r <= !(port.output_strobe && t_full_r);
            if (sync_r && !wide_r)
                oe_hi_n_r <= 1'b0;
            else if (tris_r)
                oe_hi_n_r <= 1'b1;
            else
                oe_hi_n_r <= !(port.output_strobe && t_full_r && wide_r);
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign rx_quadlet = wq_r;
    assign rx_len = wlen;
    assign rx_valid = rx_valid_r;
    assign tx_ready = tx_ready_r;
    assign port.input_busy_flag = busy_r;
    assign port.output_available_flag = avail_r;
    assign port.dev_dout = dout_r;
    assign port.dev_oe_lo_n = oe_lo_n_r;
    assign port.dev_oe_hi_n = oe_hi_n_r;
endmodule : adhp_dev

//--- logic/adhp_host.sv
`timescale 1ns/1ps
module adhp_host
    import adhp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    adhp_if.host port,
    input wire logic wide,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire adhp_pkg::adhp_word_t cmd_word,
    input wire logic cmd_last,
    output logic cmd_ready,
    output logic rsp_valid,
    output adhp_pkg::adhp_word_t rsp_word
);
    import adhp_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_HIGH, H_LOW} adhp_hst_t;

    adhp_hst_t st_r;
    logic [CNT_W-1:0] cnt_r;
    logic write_r;
    logic pad_r;
    logic half_r;
    adhp_word_t dout_r;
    logic oe_n_r;
    logic istb_r;
    logic ostb_r;
    logic ready_r;
    logic rsp_valid_r;
    adhp_word_t rsp_r;
    logic flag_ok;

    assign flag_ok = write_r ? !port.input_busy_flag :
        port.output_available_flag;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= H_IDLE;
            cnt_r <= 4'h0;
            write_r <= 1'b0;
            pad_r <= 1'b0;
            half_r <= 1'b0;
            dout_r <= 16'h0000;
            oe_n_r <= 1'b1;
            istb_r <= 1'b0;
            ostb_r <= 1'b0;
            ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_r <= 16'h0000;
        end
        else
        begin
            rsp_valid_r <= 1'b0;
            case (st_r)
                H_IDLE:
                begin
                    ready_r <= !pad_r;
                    if (pad_r)
                    begin
                        dout_r <= 16'h0000;
                        write_r <= 1'b1;
                        pad_r <= 1'b0;
                        st_r <= H_WAIT;
                    end
                    else if (cmd_valid && ready_r)
                    begin
                        ready_r <= 1'b0;
                        dout_r <= cmd_word;
                        write_r <= cmd_write;
                        // Lone wide word gets a zero partner
                        pad_r <= cmd_write && wide && cmd_last &&
                            !half_r;
                        st_r <= H_WAIT;
                    end
                end
                H_WAIT:
                begin
                    cnt_r <= 4'h0;
                    if (flag_ok)
                    begin
                        istb_r <= write_r;
                        ostb_r <= !write_r;
                        oe_n_r <= !write_r;
                        st_r <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    cnt_r <= 4'(cnt_r + 4'h1);
                    if (cnt_r == STROBE_CNT)
                    begin
                        // Data held past the fall so the device sees it
                        istb_r <= 1'b0;
                        ostb_r <= 1'b0;
                        rsp_r <= port.port_data_bus;
                        rsp_valid_r <= !write_r;
                        if (write_r && wide)
                            half_r <= !half_r;
                        cnt_r <= 4'h0;
                        st_r <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    oe_n_r <= 1'b1;
                    cnt_r <= 4'(cnt_r + 4'h1);
                    if (cnt_r == STROBE_CNT)
                        st_r <= H_IDLE;
                end
                default:
                    st_r <= H_IDLE;
            endcase
        end
    end

    assign cmd_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_word = rsp_r;
    assign port.input_strobe = istb_r;
    assign port.output_strobe = ostb_r;
    assign port.host_dout = dout_r;
    assign port.host_oe_n = oe_n_r;
endmodule : adhp_host

//--- verif/adhp_asserts.sv
`timescale 1ns/1ps
module adhp_asserts
    import adhp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic input_strobe,
    input wire logic output_strobe,
    input wire logic input_busy_flag,
    input wire logic output_available_flag,
    input wire adhp_pkg::adhp_word_t dev_dout,
    input wire logic dev_oe_lo_n,
    input wire logic host_oe_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_wr_after_idle: assert property (
        $rose(input_strobe) |-> !$past(input_busy_flag))
        else $error("Input strobe rose while busy");
    a_busy_answer: assert property (
        $rose(input_strobe) |=> input_busy_flag)
        else $error("Busy flag missing after input strobe");
    a_wr_strobe_width: assert property (
        $rose(input_strobe) |-> input_strobe [*7])
        else $error("Input strobe high phase too short");
    a_wr_data_driven: assert property (
        $fell(input_strobe) |-> !$past(host_oe_n))
        else $error("Write data not driven at strobe fall");
    a_no_contention: assert property (
        !host_oe_n |-> dev_oe_lo_n)
        else $error("Both ends drive the low lanes");
    a_rd_after_avail: assert property (
        $rose(output_strobe) |-> $past(output_available_flag))
        else $error("Output strobe rose without available");
    a_avail_answer: assert property (
        $rose(output_strobe) |=> !output_available_flag && !dev_oe_lo_n)
        else $error("No drive or available kept after strobe");
    a_rd_low_width: assert property (
        $fell(output_strobe) |-> !output_strobe [*7])
        else $error("Output strobe low phase too short");
    a_rd_data_hold: assert property (
        output_strobe && !dev_oe_lo_n && !$past(dev_oe_lo_n)
        |-> $stable(dev_dout[7:0]))
        else $error("Read data changed while strobe high");
    a_rd_release: assert property (
        $fell(output_strobe) |-> ##[0:2] dev_oe_lo_n)
        else $error("Device kept driving after read");
endmodule : adhp_asserts

//--- verif/tb_async_handshake_data_port.sv
`timescale 1ns/1ps
module tb_async_handshake_data_port;
    import adhp_pkg::*;
    logic ref_clk;
    logic reset_n;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    adhp_quad_t rx_quadlet;
    adhp_len_t rx_len;
    logic rx_valid;
    logic rx_ready;
    adhp_quad_t tx_quadlet;
    adhp_len_t tx_len;
    logic tx_valid;
    logic tx_ready;
    logic wide;
    logic cmd_valid;
    logic cmd_write;
    adhp_word_t cmd_word;
    logic cmd_last;
    logic cmd_ready;
    logic rsp_valid;
    adhp_word_t rsp_word;
    int errors;
    int compares;
    int strobes;
    logic ps_q;
    logic hi_seen;
    logic [DATA_W-1:0] rd;

    adhp_if bus_if ();
    adhp_dev i_adhp_dev (.ref_clk, .reset_n, .port(bus_if), .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .rx_quadlet, .rx_len, .rx_valid, .rx_ready,
        .tx_quadlet, .tx_len, .tx_valid, .tx_ready);
    adhp_host i_adhp_host (.ref_clk, .reset_n, .port(bus_if), .wide,
        .cmd_valid, .cmd_write, .cmd_word, .cmd_last, .cmd_ready,
        .rsp_valid, .rsp_word);
    adhp_asserts i_adhp_asserts (.ref_clk, .reset_n,
        .input_strobe(bus_if.input_strobe),
        .output_strobe(bus_if.output_strobe),
        .input_busy_flag(bus_if.input_busy_flag),
        .output_available_flag(bus_if.output_available_flag),
        .dev_dout(bus_if.dev_dout), .dev_oe_lo_n(bus_if.dev_oe_lo_n),
        .host_oe_n(bus_if.host_oe_n));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Counts write words actually put on the wire
    always @(posedge ref_clk)
    begin
        ps_q <= bus_if.input_strobe;
        if (bus_if.input_strobe && !ps_q)
            strobes <= strobes + 1;
        if (!bus_if.dev_oe_hi_n)
            hi_seen <= 1'b1;
    end

    task automatic complete_run();
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk(string name, adhp_quad_t seen, adhp_quad_t exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic avs(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge ref_clk);
        for (int k = 0; k < 50 && avs_waitrequest !== 1'b0; k++)
            @(posedge ref_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : avs

    // Read commands also wait for the answer word
    task automatic cmd(logic w, adhp_word_t d, logic l);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_word <= d;
        cmd_last <= l;
        @(posedge ref_clk);
        for (int k = 0; k < 500 && cmd_ready !== 1'b1; k++)
            @(posedge ref_clk);
        cmd_valid <= 1'b0;
        for (int k = 0; k < 500 && !w && rsp_valid !== 1'b1; k++)
            @(posedge ref_clk);
    endtask : cmd

    function automatic adhp_word_t exp_w(logic wd, logic le, adhp_len_t n,
        adhp_quad_t q, int i);
        logic [7:0] b [4];
        for (int k = 0; k < 4; k++)
            b[k] = (k < n) ? q[31-8*k -: 8] : 8'h00;
        if (!wd)
            return {8'h00, le ? b[n-1-i] : b[i]};
        if (le)
            return (i == 0) ? {b[2], b[3]} : {b[0], b[1]};
        return (i == 0) ? {b[0], b[1]} : {b[2], b[3]};
    endfunction : exp_w

    function automatic logic [31:0] cfg(logic t, logic le, adhp_len_t n,
        logic s, logic wd);
        return {t, 14'h0, le, 6'h0, n[1:0], 6'h0, s, wd};
    endfunction : cfg

    task automatic t_regs();
        avs(1'b0, OFS_FIFO_CLR, 32'h0);
        chk("status_idle", rd, 32'h0);
        avs(1'b0, OFS_MODE, 32'h0);
        chk("mode_reset", rd, REG_RESET);
        avs(1'b1, 8'h40, 32'hffff_ffff);
        avs(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        avs(1'b1, OFS_MODE, cfg(1'b1, 1'b1, 3'h3, 1'b1, 1'b0));
        avs(1'b0, OFS_MODE, 32'h0);
        chk("mode_rw", rd, 32'h8001_0302);
        repeat (3) @(posedge ref_clk);
        chk("sync_upper", 32'(bus_if.dev_oe_hi_n), 32'h0);
    endtask : t_regs

    task automatic t_write(logic wd, logic le, adhp_len_t n, adhp_quad_t q,
        logic hold);
        int nw;
        nw = wd ? 2 : int'(n);
        avs(1'b1, OFS_MODE, cfg(1'b0, le, n, 1'b0, wd));
        wide <= wd;
        strobes = 0;
        for (int i = 0; i < nw; i++)
            cmd(1'b1, exp_w(wd, le, n, q, i), i == nw - 1);
        for (int k = 0; k < 500 && rx_valid !== 1'b1; k++)
            @(posedge ref_clk);
        chk("rx_quadlet", rx_quadlet,
            q & (32'hffff_ffff << (32 - 8 * n)));
        chk("rx_len", 32'(rx_len), 32'(n));
        chk("strobes", 32'(strobes), 32'(nw));
        if (!hold)
        begin
            @(posedge ref_clk);
            rx_ready <= 1'b1;
            @(posedge ref_clk);
            rx_ready <= 1'b0;
        end
    endtask : t_write

    task automatic t_read(logic wd, logic le, adhp_len_t n, adhp_quad_t q,
        logic t);
        int nw;
        adhp_word_t w;
        nw = wd ? 2 : int'(n);
        avs(1'b1, OFS_MODE, cfg(t, le, n, 1'b0, wd));
        wide <= wd;
        hi_seen = 1'b0;
        @(posedge ref_clk);
        tx_quadlet <= q;
        tx_len <= n;
        tx_valid <= 1'b1;
        @(posedge ref_clk);
        for (int k = 0; k < 500 && tx_ready !== 1'b1; k++)
            @(posedge ref_clk);
        tx_valid <= 1'b0;
        for (int i = 0; i < nw; i++)
        begin
            cmd(1'b0, 16'h0, i == nw - 1);
            w = wd ? rsp_word : {8'h00, rsp_word[7:0]};
            chk("rsp_word", 32'(w),
                32'(exp_w(wd, le, n, q, i)));
        end
        if (t)
            chk("upper_released", 32'(hi_seen), 32'h0);
    endtask : t_read

    task automatic t_flush();
        t_write(1'b0, 1'b0, 3'h4, 32'h1122_3344, 1'b1);
        avs(1'b1, OFS_FIFO_CLR, 32'h8000_0000);
        repeat (3) @(posedge ref_clk);
        chk("rx_kept", 32'(rx_valid), 32'h1);
        chk("busy_pending", 32'(bus_if.input_busy_flag), 32'h1);
        avs(1'b1, OFS_FIFO_CLR, 32'hc000_0000);
        repeat (3) @(posedge ref_clk);
        chk("rx_flushed", 32'(rx_valid), 32'h0);
    endtask : t_flush

    task automatic t_port_reset();
        avs(1'b1, OFS_MODE, cfg(1'b0, 1'b1, 3'h2, 1'b0, 1'b1));
        @(posedge ref_clk);
        tx_quadlet <= 32'h5566_7788;
        tx_len <= 3'h2;
        tx_valid <= 1'b1;
        @(posedge ref_clk);
        for (int k = 0; k < 500 && tx_ready !== 1'b1; k++)
            @(posedge ref_clk);
        tx_valid <= 1'b0;
        for (int k = 0; k < 500 && !bus_if.output_available_flag; k++)
            @(posedge ref_clk);
        avs(1'b1, OFS_MODE, cfg(1'b0, 1'b1, 3'h2, 1'b0, 1'b1) | 32'h6000_0000);
        repeat (3) @(posedge ref_clk);
        chk("avail_cleared", 32'(bus_if.output_available_flag), 32'h0);
        avs(1'b0, OFS_MODE, 32'h0);
        chk("mode_kept", rd, cfg(1'b0, 1'b1, 3'h2, 1'b0, 1'b1));
    endtask : t_port_reset

    initial
    begin
        #200000;
        errors++;
        complete_run();
    end

    initial
    begin
        {reset_n, avs_read, avs_write, rx_ready, tx_valid, wide} = '0;
        {cmd_valid, cmd_write, cmd_last, ps_q, hi_seen} = '0;
        avs_address = '0;
        avs_writedata = '0;
        tx_quadlet = '0;
        tx_len = '0;
        cmd_word = '0;
        errors = 0;
        compares = 0;
        strobes = 0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_flush();
        t_port_reset();
        for (int m = 0; m < 16; m++)
        begin
            t_write(m[0], m[1], 3'(m[3:2] + 1), 32'ha1b2_c3d4 + m, 1'b0);
            t_read(m[0], m[1], 3'(m[3:2] + 1), 32'h9e8d_7c6b - m, 1'b0);
        end
        t_read(1'b0, 1'b0, 3'h4, 32'h0f1e_2d3c, 1'b1);
        complete_run();
    end
endmodule : tb_async_handshake_data_port
